// *** rtl/dbs_pkg.sv ***
// dbs_pkg: shared constants and types of the burst-of-four ddr sram pin interface.
// assumes one core clock (125 mhz) that oversamples the input strobe pair.
package dbs_pkg;

  // lanes and widths, x18 arrangement on a 36-lane bus
  localparam int DATA_W = 18;
  localparam int LANE_W = 36;
  localparam int ADDR_W = 19;
  localparam int BEAT_W = 2;
  localparam int MEM_AW = ADDR_W + BEAT_W;
  localparam logic [BEAT_W-1:0] LAST_BEAT = 2'h3;

  // command pipeline, indexed in strobe half-cycles after the command edge
  localparam int PIPE_LEN = 5;
  localparam int RD_TAP_DLL = 4; // first beat at edge 5: 2.5 cycles
  localparam int RD_TAP_BYP = 1; // first beat at edge 2: 1 cycle
  localparam int WR_TAP = 1; // first write beat one cycle late

  // clocking limits
  localparam int BYPASS_MAX_MHZ = 167;
  localparam int LOCK_K_CYCLES_DEF = 2048;
  localparam int LOCK_CNT_W = 16;

  // delay-locked loop status
  typedef enum logic [1:0]
  {
    DBS_DLL_BYPASS = 2'b00,
    DBS_DLL_LOCKING = 2'b01,
    DBS_DLL_LOCKED = 2'b10
  } dbs_dll_e;

endpackage : dbs_pkg

// *** rtl/dbs_mem.sv ***
// dbs_mem: storage array, one write port, one read port with registered data.
// assumes write and read addresses never collide in the same clock.
`timescale 1ns/10ps
module dbs_mem
  import dbs_pkg::*;
(
  // clock
  input wire logic clk,
  // write port
  input wire logic wr_en,
  input wire logic [MEM_AW-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic [MEM_AW-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];

  // array has no reset; contents are undefined until written
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : dbs_mem

// *** rtl/dbs_sram_if.sv ***
// dbs_sram_if: pin-level logic of a ddr burst-of-four common-io static memory.
// assumes the strobe pair, commands and data arrive asynchronously and are
// oversampled by clk, which must be several times faster than the strobe.
//
// Summary of operation
// - address, load and direction are taken only on true strobe rising edges.
// - write data taken on true and complement strobe rising edges.
// - echo strobes toggle always, also while the data bus floats.
// - bypass pin low bypasses the loop and forgets its lock.
// - bypass pin high starts the loop; lock follows after the lock time.
// - bypassed loop gives one-cycle read latency; controller runs at most 167 mhz.
// - read valid is high exactly while read data drives, aligned to echoes.
// - address ignored in cycles where load is not low.
// - read beats driven on the bus, each aligned with an echo edge.
// - only lanes 0 to 17 used; upper lanes treated as unconnected.
// - with load low, direction high means read, low means write.
// - every read and write is a burst of four beats.
// - with loop on, first read beat 2.5 cycles after command, then each following half-cycle edge.
// - load high is a no-op and never aborts a running read burst.
`timescale 1ns/10ps
module dbs_sram_if
  import dbs_pkg::*;
#(
  parameter int LOCK_K_CYCLES = LOCK_K_CYCLES_DEF
)
(
  // core clock and reset
  input wire logic clk,
  input wire logic reset,
  // input strobe pair
  input wire logic strobe_k,
  input wire logic strobe_k_n,
  // command pins
  input wire logic load_n,
  input wire logic rw_sel,
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic dll_bypass_n,
  // two-way data bus
  input wire logic [LANE_W-1:0] data_io_in,
  output logic [LANE_W-1:0] data_io_out,
  output logic [LANE_W-1:0] data_io_oe,
  // echo and status
  output logic echo_strobe,
  output logic echo_strobe_n,
  output logic read_data_valid,
  output logic dll_locked
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic k_s1, k_s2, k_s3, kn_s1, kn_s2, kn_s3;
  logic ld_s1, ld_s2, rw_s1, rw_s2, dll_s1, dll_s2;
  logic [ADDR_W-1:0] addr_s1, addr_s2;
  logic [DATA_W-1:0] din_s1, din_s2;
  logic k_d1, kn_d1;
  logic [PIPE_LEN-1:0] pv_r, prd_r;
  logic [ADDR_W-1:0] pa_r [PIPE_LEN];
  logic rd_act_r, wr_act_r;
  logic [BEAT_W-1:0] rd_beat_r, wr_beat_r;
  logic [ADDR_W-1:0] rd_addr_r, wr_addr_r;
  logic emit_r, emit_rd_r;
  dbs_dll_e dll_r;
  logic [LOCK_CNT_W-1:0] lock_cnt_r;
  logic [DATA_W-1:0] mem_rdata;
  logic [LANE_W-1:0] data_out_r, data_oe_r;
  logic echo_r, echo_n_r, valid_r, locked_r;

  // word address of one beat within a burst
  function automatic logic [MEM_AW-1:0] burst_addr(input logic [ADDR_W-1:0] a,
                                                  input logic [BEAT_W-1:0] b);
    burst_addr = {a, b};
  endfunction : burst_addr

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; every pin goes through the same two stages so that
  // data and commands stay aligned with the detected strobe edges

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      {k_s1, k_s2, k_s3, kn_s1, kn_s2, kn_s3} <= 6'h00;
      {ld_s1, ld_s2, rw_s1, rw_s2, dll_s1, dll_s2} <= 6'h3c;
      addr_s1 <= '0;
      addr_s2 <= '0;
      din_s1 <= '0;
      din_s2 <= '0;
    end
    else
    begin
      k_s1 <= strobe_k;
      k_s2 <= k_s1;
      k_s3 <= k_s2;
      kn_s1 <= strobe_k_n;
      kn_s2 <= kn_s1;
      kn_s3 <= kn_s2;
      ld_s1 <= load_n;
      ld_s2 <= ld_s1;
      rw_s1 <= rw_sel;
      rw_s2 <= rw_s1;
      dll_s1 <= dll_bypass_n;
      dll_s2 <= dll_s1;
      addr_s1 <= address_in;
      addr_s2 <= addr_s1;
      din_s1 <= data_io_in[DATA_W-1:0];
      din_s2 <= din_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge detection and command decode

  wire k_rise = k_s2 & ~k_s3;
  wire kn_rise = kn_s2 & ~kn_s3;
  wire half_edge = k_rise | kn_rise;
  wire cmd = k_rise & ~ld_s2;
  wire bypass = (dll_r == DBS_DLL_BYPASS);
  wire [2:0] rd_tap = bypass ? 3'(RD_TAP_BYP) : 3'(RD_TAP_DLL);
  wire rd_start = half_edge & pv_r[rd_tap] & prd_r[rd_tap];
  wire wr_start = half_edge & pv_r[WR_TAP] & ~prd_r[WR_TAP];
  wire mem_re = rd_start | (half_edge & rd_act_r);
  wire mem_we = wr_start | (half_edge & wr_act_r);
  wire [MEM_AW-1:0] mem_raddr = rd_start ? burst_addr(pa_r[rd_tap], 2'h0)
                                         : burst_addr(rd_addr_r, rd_beat_r);
  wire [MEM_AW-1:0] mem_waddr = wr_start ? burst_addr(pa_r[WR_TAP], 2'h0)
                                         : burst_addr(wr_addr_r, wr_beat_r);

  //////////////////////////////////////////////////////////////////////////////
  // command pipeline, one stage per strobe half-cycle

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pv_r <= '0;
      prd_r <= '0;
    end
    else if (half_edge)
    begin
      pv_r <= {pv_r[PIPE_LEN-2:0], cmd};
      prd_r <= {prd_r[PIPE_LEN-2:0], rw_s2};
    end
  end

  // addresses carry no reset; they are qualified by pv_r
  always_ff @(posedge clk)
  begin
    if (half_edge)
    begin
      pa_r[0] <= addr_s2;
      for (int i = 1; i < PIPE_LEN; i++)
      begin
        pa_r[i] <= pa_r[i-1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // burst engines; a new start simply takes over, load high never stops one

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_act_r <= 1'b0;
      rd_beat_r <= '0;
      rd_addr_r <= '0;
    end
    else if (rd_start)
    begin
      rd_act_r <= 1'b1;
      rd_beat_r <= 2'h1;
      rd_addr_r <= pa_r[rd_tap];
    end
    else if (half_edge & rd_act_r)
    begin
      rd_act_r <= (rd_beat_r != LAST_BEAT);
      rd_beat_r <= rd_beat_r + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_act_r <= 1'b0;
      wr_beat_r <= '0;
      wr_addr_r <= '0;
    end
    else if (wr_start)
    begin
      wr_act_r <= 1'b1;
      wr_beat_r <= 2'h1;
      wr_addr_r <= pa_r[WR_TAP];
    end
    else if (half_edge & wr_act_r)
    begin
      wr_act_r <= (wr_beat_r != LAST_BEAT);
      wr_beat_r <= wr_beat_r + 2'h1;
    end
  end

  // write beats land in the array on the edge that carries them
  dbs_mem i_dbs_mem
  (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(din_s2),
    .rd_en(mem_re),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // delay-locked loop model: lock counted in true strobe cycles

  always_ff @(posedge clk)
  begin
    if (reset | ~dll_s2)
    begin
      dll_r <= DBS_DLL_BYPASS;
      lock_cnt_r <= '0;
    end
    else if (dll_r == DBS_DLL_BYPASS)
    begin
      dll_r <= DBS_DLL_LOCKING;
    end
    else if (dll_r == DBS_DLL_LOCKING && k_rise)
    begin
      lock_cnt_r <= lock_cnt_r + 16'h0001;
      if (lock_cnt_r == LOCK_CNT_W'(LOCK_K_CYCLES - 1))
      begin
        dll_r <= DBS_DLL_LOCKED;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output stage; strobes are delayed by the same two clocks as the array
  // read so that echoes, valid and data switch together

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      emit_r <= 1'b0;
      emit_rd_r <= 1'b0;
      k_d1 <= 1'b0;
      kn_d1 <= 1'b0;
      echo_r <= 1'b0;
      echo_n_r <= 1'b0;
    end
    else
    begin
      emit_r <= half_edge;
      emit_rd_r <= mem_re;
      k_d1 <= k_s2;
      kn_d1 <= kn_s2;
      echo_r <= k_d1;
      echo_n_r <= kn_d1;
    end
  end

  // each beat holds until the next half-cycle edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      data_out_r <= '0;
      data_oe_r <= '0;
      valid_r <= 1'b0;
    end
    else if (emit_r)
    begin
      valid_r <= emit_rd_r;
      data_oe_r <= {{(LANE_W-DATA_W){1'b0}}, {DATA_W{emit_rd_r}}};
      if (emit_rd_r)
      begin
        data_out_r <= {{(LANE_W-DATA_W){1'b0}}, mem_rdata};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      locked_r <= 1'b0;
    end
    else
    begin
      locked_r <= (dll_r == DBS_DLL_LOCKED);
    end
  end

  assign data_io_out = data_out_r;
  assign data_io_oe = data_oe_r;
  assign echo_strobe = echo_r;
  assign echo_strobe_n = echo_n_r;
  assign read_data_valid = valid_r;
  assign dll_locked = locked_r;

endmodule : dbs_sram_if

// *** verif/dbs_sram_if_sva.sv ***
// checker: port-level properties of the ddr sram pin interface.
// assumes a bind onto dbs_sram_if; one clock, synchronous reset.
`timescale 1ns/10ps
module dbs_sram_if_sva
  import dbs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched input
  input wire logic dll_bypass_n,
  // watched outputs
  input wire logic [LANE_W-1:0] data_io_out,
  input wire logic [LANE_W-1:0] data_io_oe,
  input wire logic echo_strobe,
  input wire logic echo_strobe_n,
  input wire logic read_data_valid,
  input wire logic dll_locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [4:0] idle_r;
  //////////////////////////////
  // cycles since the echo last moved; saturates so it cannot wrap
  always_ff @(posedge clk)
    if (reset || $changed(echo_strobe)) idle_r <= 5'h00;
    else if (idle_r != 5'h1f) idle_r <= idle_r + 5'h01;
  //////////////////////////////
  // lanes and enables
  upper_lanes_a: assert property (data_io_out[35:18] == '0 && data_io_oe[35:18] == '0)
    else $error("upper lanes driven");
  lane_enable_a: assert property ((&data_io_oe[17:0]) || !(|data_io_oe[17:0]))
    else $error("lower lane enables differ");
  valid_oe_a: assert property (read_data_valid == data_io_oe[0])
    else $error("valid differs from drive");
  // valid and beats move only with an echo edge
  valid_rise_a: assert property ($rose(read_data_valid)
    |-> $rose(echo_strobe) || $rose(echo_strobe_n))
    else $error("valid rose off an echo edge");
  valid_fall_a: assert property ($fell(read_data_valid)
    |-> $rose(echo_strobe) || $rose(echo_strobe_n))
    else $error("valid fell off an echo edge");
  beat_align_a: assert property (read_data_valid && $past(read_data_valid) && $changed(data_io_out)
    |-> $rose(echo_strobe) || $rose(echo_strobe_n))
    else $error("beat changed off an echo edge");
  // echo keeps running; a half strobe period is under 8 cycles
  echo_run_a: assert property (idle_r < 5'h10)
    else $error("echo strobe stalled");
  valid_run_a: assert property ($rose(read_data_valid) |-> read_data_valid [*8])
    else $error("read burst cut short");
  // loop state follows the bypass pin
  bypass_drop_a: assert property (!dll_bypass_n [*6] |-> !dll_locked)
    else $error("lock kept while bypassed");
  lock_cause_a: assert property ($rose(dll_locked) |-> dll_bypass_n)
    else $error("lock without loop enabled");
endmodule : dbs_sram_if_sva

bind dbs_sram_if dbs_sram_if_sva i_dbs_sram_if_sva (.clk(clk), .reset(reset),
  .dll_bypass_n(dll_bypass_n), .data_io_out(data_io_out), .data_io_oe(data_io_oe),
  .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n),
  .read_data_valid(read_data_valid), .dll_locked(dll_locked));

// *** verif/dbs_ctrl_model.sv ***
// controller model: strobe pair, commands and write data toward the pins.
// assumes the bench resolves the bus; strobe period 125 ns, free running.
`timescale 1ns/10ps
module dbs_ctrl_model
  import dbs_pkg::*;
(
  // strobe pair
  output logic k,
  output logic k_n,
  // command pins
  output logic load_n,
  output logic rw_sel,
  output logic [ADDR_W-1:0] address_in,
  // bus drive
  output logic [LANE_W-1:0] dq
);
  logic [1:0] ph = 2'h0;
  //////////////////////////////
  // quarter-period phase; k rises at phase 0, k_n at phase 2
  always #31.25 ph <= ph + 2'h1;
  assign k = (ph < 2'h2);
  assign k_n = ~k;
  // idle pins at time zero
  initial
  begin
    load_n = 1'b1;
    rw_sel = 1'b0;
    address_in = '0;
    dq = '0;
  end
  // one burst; pins move mid-way between sampling edges
  task automatic op(input logic rd, input logic [ADDR_W-1:0] a,
                    input logic [4*LANE_W-1:0] w);
    int i;
    @(posedge k_n);
    load_n <= 1'b0;
    rw_sel <= rd;
    address_in <= a;
    @(posedge k_n);
    load_n <= 1'b1;
    address_in <= ~a;
    if (!rd)
    begin
      #31.25;
      for (i = 0; i < 4; i++)
      begin
        dq <= w[i*LANE_W +: LANE_W];
        #62.5;
      end
      dq <= ~dq; // released bus has no pull: inverse of last
    end
  endtask : op
endmodule : dbs_ctrl_model

// *** verif/tb_dbs_sram_if.sv ***
// bench: writes and reads bursts through the pins with the loop on, then reads one burst bypassed.
// assumes dbs_ctrl_model on the far side and the bound checker.
`timescale 1ns/10ps
module tb_dbs_sram_if
  import dbs_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic dll_bypass_n = 1'b0;
  logic k, k_n, load_n, rw_sel;
  logic [ADDR_W-1:0] address_in;
  logic [LANE_W-1:0] dq, data_io_in, data_io_out, data_io_oe;
  logic echo_strobe, echo_strobe_n, read_data_valid, dll_locked;
  logic [4*LANE_W-1:0] wa, wb;
  int mismatches = 0;
  int total_checks = 0;
  //////////////////////////////
  // clock and resolved bus
  always #4 clk = ~clk;
  assign data_io_in = (data_io_oe & data_io_out) | (~data_io_oe & dq);
  dbs_sram_if #(.LOCK_K_CYCLES(4)) i_dbs_sram_if (.clk(clk), .reset(reset),
    .strobe_k(k), .strobe_k_n(k_n), .load_n(load_n), .rw_sel(rw_sel),
    .address_in(address_in), .dll_bypass_n(dll_bypass_n), .data_io_in(data_io_in),
    .data_io_out(data_io_out), .data_io_oe(data_io_oe), .echo_strobe(echo_strobe),
    .echo_strobe_n(echo_strobe_n), .read_data_valid(read_data_valid),
    .dll_locked(dll_locked));
  dbs_ctrl_model i_dbs_ctrl_model (.k(k), .k_n(k_n), .load_n(load_n),
    .rw_sel(rw_sel), .address_in(address_in), .dq(dq));
  //////////////////////////////
  task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // lower lanes of four beats, beat 0 lowest
  function automatic logic [71:0] lanes(input logic [4*LANE_W-1:0] w);
    for (int i = 0; i < 4; i++) lanes[i*DATA_W +: DATA_W] = w[i*LANE_W +: DATA_W];
  endfunction : lanes
  // beats sampled mid-beat; a beat lasts about 7.8 cycles. latency counted in
  // clocks from the command's true strobe edge: half-edges of 62.5 ns plus
  // about four clocks of pin sampling and output registers
  task automatic grab(input logic on, output logic [71:0] q);
    int n;
    int lat;
    lat = ((on ? RD_TAP_DLL : RD_TAP_BYP) + 1) * 625 / 80 + 4;
    @(negedge load_n);
    @(posedge k);
    for (n = 0; n < 400 && read_data_valid !== 1'b1; n++) @(negedge clk);
    check("read_latency", 1'b1, n >= lat - 3 && n <= lat + 3);
    check("first_edge", !on, echo_strobe);
    for (n = 0; n < 36; n++)
    begin
      if (n % 8 == 3 && n < 32) q[(n/8)*DATA_W +: DATA_W] = data_io_out[DATA_W-1:0];
      @(negedge clk);
    end
    check("burst_end", 1'b0, read_data_valid);
  endtask : grab
  task automatic rd_chk(input logic on, input logic [ADDR_W-1:0] a,
                        input logic [4*LANE_W-1:0] w);
    logic [71:0] q;
    fork
      i_dbs_ctrl_model.op(1'b1, a, '0);
      grab(on, q);
    join
    check("read_burst", lanes(w), q);
  endtask : rd_chk
  //////////////////////////////
  task automatic t_lock();
    @(posedge clk) dll_bypass_n <= 1'b1;
    repeat (20) @(negedge clk);
    check("lock_early", 1'b0, dll_locked);
    repeat (128) @(negedge clk);
    check("lock_late", 1'b1, dll_locked);
  endtask : t_lock
  // second address is the first one inverted, the noise seen while idle
  task automatic t_dll_rw();
    wa = {36'h12342aaaa, 36'h876515555, 36'hfffc3c3c3, 36'h00000ffff};
    wb = ~wa;
    i_dbs_ctrl_model.op(1'b0, 19'h00005, wa);
    i_dbs_ctrl_model.op(1'b0, 19'h7fffa, wb);
    rd_chk(1'b1, 19'h00005, wa);
    rd_chk(1'b1, 19'h7fffa, wb);
  endtask : t_dll_rw
  task automatic t_bypass();
    @(posedge clk) dll_bypass_n <= 1'b0;
    repeat (8) @(negedge clk);
    check("bypass_lock", 1'b0, dll_locked);
    rd_chk(1'b0, 19'h7fffa, wb);
  endtask : t_bypass
  //////////////////////////////
  // main sequence
  initial
  begin
    repeat (12) @(negedge clk);
    check("reset_oe", '0, data_io_oe);
    check("reset_valid", 1'b0, read_data_valid);
    @(posedge clk) reset <= 1'b0;
    t_lock();
    t_dll_rw();
    t_bypass();
    summarize();
  end
  // watchdog, several times the expected run
  initial
  begin
    #30000;
    mismatches++;
    summarize();
  end
endmodule : tb_dbs_sram_if
